/* rtl/reset_cause_and_pin_irq_ctrl.v */
/*
  Reset cause status and external pin interrupt control registers.
  Assumes rst_n is the power-on reset of this block, all inputs are
  synchronous to sys_clk, and the chip resets itself from sys_reset_req.
*/
// Added by the designer: the address-and-strobe port and the register addresses.
// Operation
// - Writing one to acknowledge clears the pin flag; zero ignored; reads zero.
// - In level mode acknowledge cannot clear flag while pin stays asserted.
// - Interrupt enable one requests interrupt while flag set; zero means polling.
// - Mode bit zero detects edges only; one detects edges and levels.
// - Polarity select sets polarity of edges and levels in both modes.
// - Cause register holds read-only flags for the most recent reset source.
// - Debug forced reset clears every cause flag; a low-voltage reset in the same cycle still sets its flag here.
// - Any write to cause register restarts watchdog, contents unchanged.
// - Power-on sets power-on and low-voltage flags; low-voltage sets only its flag.
// - Other resets set flags of sources active at entry; clear power-on and low-voltage.
// - External pin flag set when reset came from low level on reset pin.
// - Watchdog flag set on watchdog timeout; source blocked while watchdog disabled.
// - Bad opcode flag on unimplemented opcode, disallowed stop or debug halt.
// - Bad address flag on access to unimplemented memory address.
// - Low-voltage trip with reset enable resets and sets low-voltage flag.
// - Pin event flag is read-only and sets on a qualifying pin event.
// - Polarity zero selects falling or low; one selects rising or high.
// - Pin event detection works only while pin function enable is one.
`timescale 1ns/1ps
`include "reset_cause_consts.vh"

module reset_cause_and_pin_irq_ctrl (
  input wire sys_clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire irq_pin_in,
  output wire pin_irq_req,
  output wire pin_pull_dis,
  input wire ext_reset_pin_n,
  input wire watchdog_timeout,
  input wire watchdog_en,
  input wire bad_opcode_exec,
  input wire stop_exec,
  input wire stop_allow,
  input wire halt_to_debug_instr,
  input wire halt_to_debug_instr_mode_en,
  input wire bad_address_access,
  input wire low_voltage_trip,
  input wire low_voltage_reset_en,
  input wire debug_force_reset,
  output reg watchdog_clear,
  output wire sys_reset_req
);

  // ----------------------------------------
  // States and timing
  // ----------------------------------------
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;
  localparam integer HOLD_CYC_INT = (`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [7:0] HOLD_CYC = HOLD_CYC_INT[7:0];

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] hold_cnt_ff;
  reg [7:0] nxt_hold_cnt;
  reg [7:0] cause_ff;
  reg [7:0] nxt_cause;
  reg pull_dis_ff;
  reg polarity_ff;
  reg func_en_ff;
  reg int_en_ff;
  reg level_mode_ff;
  reg [7:0] nxt_rdata;
  wire pin_event_flag;
  wire ctrl_wr;
  wire cause_wr;
  wire ack_pulse;
  wire src_ext_pin;
  wire src_watchdog;
  wire src_bad_opcode;
  wire src_bad_address;
  wire src_low_voltage;
  wire any_source;
  wire in_run;
  wire chip_reset;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign ctrl_wr = wr_en & (addr == `PIN_CTRL_ADDR);
  assign cause_wr = wr_en & (addr == `RESET_CAUSE_ADDR);
  assign ack_pulse = ctrl_wr & wdata[`PIN_ACK_BIT];

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  assign src_ext_pin = ~ext_reset_pin_n;
  assign src_watchdog = watchdog_timeout & watchdog_en;
  assign src_bad_opcode = bad_opcode_exec
                        | (stop_exec & ~stop_allow)
                        | (halt_to_debug_instr & ~halt_to_debug_instr_mode_en);
  assign src_bad_address = bad_address_access;
  assign src_low_voltage = low_voltage_trip & low_voltage_reset_en;

  assign any_source = src_ext_pin
                    | src_watchdog
                    | src_bad_opcode
                    | src_bad_address
                    | src_low_voltage
                    | debug_force_reset;

  assign in_run = (state_ff == ST_RUN);

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (any_source) begin
          nxt_state = ST_HOLD;
          nxt_hold_cnt = HOLD_CYC;
        end
      end
      ST_HOLD: begin
        if (hold_cnt_ff != 8'h00) begin
          nxt_hold_cnt = hold_cnt_ff - 8'h01;
        end else if (ext_reset_pin_n) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_HOLD;
        nxt_hold_cnt = HOLD_CYC;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= ST_HOLD;
      hold_cnt_ff <= HOLD_CYC;
    end else begin
      state_ff <= nxt_state;
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  assign sys_reset_req = ~in_run;
  assign chip_reset = ~in_run;

  // ----------------------------------------
  // Reset cause capture at reset entry
  // ----------------------------------------
  always @* begin
    nxt_cause = cause_ff;
    if (in_run && any_source) begin
      if (src_low_voltage) begin
        nxt_cause = `CAUSE_LOW_VOLTAGE_VAL;
      end else if (debug_force_reset) begin
        nxt_cause = `CAUSE_DEBUG_VAL;
      end else begin
        nxt_cause = 8'h00;
        nxt_cause[`CAUSE_EXT_PIN_BIT] = src_ext_pin;
        nxt_cause[`CAUSE_WATCHDOG_BIT] = src_watchdog;
        nxt_cause[`CAUSE_BAD_OPCODE_BIT] = src_bad_opcode;
        nxt_cause[`CAUSE_BAD_ADDRESS_BIT] = src_bad_address;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cause_ff <= `CAUSE_POWER_ON_VAL;
    end else begin
      cause_ff <= nxt_cause & `CAUSE_IMPL_MASK;
    end
  end

  // ----------------------------------------
  // Watchdog restart on cause register write
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= cause_wr;
    end
  end

  // ----------------------------------------
  // Pin interrupt control register
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n || chip_reset) begin
      pull_dis_ff <= 1'b0;
      polarity_ff <= 1'b0;
      func_en_ff <= 1'b0;
      int_en_ff <= 1'b0;
      level_mode_ff <= 1'b0;
    end else if (ctrl_wr) begin
      pull_dis_ff <= wdata[`PIN_PULL_DIS_BIT];
      polarity_ff <= wdata[`PIN_POLARITY_BIT];
      func_en_ff <= wdata[`PIN_FUNC_EN_BIT];
      int_en_ff <= wdata[`PIN_INT_EN_BIT];
      level_mode_ff <= wdata[`PIN_MODE_BIT];
    end
  end

  assign pin_pull_dis = pull_dis_ff;

  // ----------------------------------------
  // Pin event detector
  // ----------------------------------------
  pin_event_detect u_pin_event_detect (
    .sys_clk(sys_clk),
    .rst_n(rst_n & in_run),
    .pin_in(irq_pin_in),
    .pin_func_en(func_en_ff),
    .pin_polarity_sel(polarity_ff),
    .pin_detect_level_mode(level_mode_ff),
    .pin_event_ack(ack_pulse),
    .pin_event_flag(pin_event_flag)
  );

  assign pin_irq_req = int_en_ff & pin_event_flag;

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  always @* begin
    nxt_rdata = 8'h00;
    if (rd_en) begin
      case (addr)
        `PIN_CTRL_ADDR: begin
          nxt_rdata[`PIN_PULL_DIS_BIT] = pull_dis_ff;
          nxt_rdata[`PIN_POLARITY_BIT] = polarity_ff;
          nxt_rdata[`PIN_FUNC_EN_BIT] = func_en_ff;
          nxt_rdata[`PIN_FLAG_BIT] = pin_event_flag;
          nxt_rdata[`PIN_ACK_BIT] = 1'b0;
          nxt_rdata[`PIN_INT_EN_BIT] = int_en_ff;
          nxt_rdata[`PIN_MODE_BIT] = level_mode_ff;
        end
        `RESET_CAUSE_ADDR: begin
          nxt_rdata = cause_ff & `CAUSE_IMPL_MASK;
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= nxt_rdata;
    end
  end

endmodule // reset_cause_and_pin_irq_ctrl

/* rtl/reset_cause_consts.vh */
/*
  Constants for the reset cause and pin interrupt control block:
  register offsets, field positions, reset values and timing.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef RESET_CAUSE_CONSTS_VH
`define RESET_CAUSE_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PIN_CTRL_ADDR 4'h0
`define RESET_CAUSE_ADDR 4'h1

// ----------------------------------------
// Pin interrupt control fields
// ----------------------------------------
`define PIN_PULL_DIS_BIT 6
`define PIN_POLARITY_BIT 5
`define PIN_FUNC_EN_BIT 4
`define PIN_FLAG_BIT 3
`define PIN_ACK_BIT 2
`define PIN_INT_EN_BIT 1
`define PIN_MODE_BIT 0
`define PIN_CTRL_RST 8'h00

// ----------------------------------------
// Reset cause fields
// ----------------------------------------
`define CAUSE_POWER_ON_BIT 7
`define CAUSE_EXT_PIN_BIT 6
`define CAUSE_WATCHDOG_BIT 5
`define CAUSE_BAD_OPCODE_BIT 4
`define CAUSE_BAD_ADDRESS_BIT 3
`define CAUSE_LOW_VOLTAGE_BIT 1
`define CAUSE_POWER_ON_VAL 8'h82
`define CAUSE_LOW_VOLTAGE_VAL 8'h02
`define CAUSE_DEBUG_VAL 8'h00
`define CAUSE_IMPL_MASK 8'hfa

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define RST_HOLD_NS 128

`endif

/* rtl/pin_event_detect.v */
/*
  Pin event detector with sticky event flag.
  Assumes the pin input is synchronous to sys_clk.
*/
`timescale 1ns/1ps

module pin_event_detect (
  input wire sys_clk,
  input wire rst_n,
  input wire pin_in,
  input wire pin_func_en,
  input wire pin_polarity_sel,
  input wire pin_detect_level_mode,
  input wire pin_event_ack,
  output reg pin_event_flag
);

  // ----------------------------------------
  // Edge and level qualification
  // ----------------------------------------
  reg asserted_prev_ff;
  wire asserted;
  wire edge_seen;
  wire pin_event;

  // Polarity one means high level or rising edge
  assign asserted = pin_polarity_sel ? pin_in : ~pin_in;
  assign edge_seen = asserted & ~asserted_prev_ff;
  assign pin_event = pin_func_en & (edge_seen | (pin_detect_level_mode & asserted));

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      asserted_prev_ff <= 1'b0;
    end else begin
      asserted_prev_ff <= asserted;
    end
  end

  // ----------------------------------------
  // Sticky flag, set wins over acknowledge
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_event_flag <= 1'b0;
    end else if (pin_event) begin
      pin_event_flag <= 1'b1;
    end else if (pin_event_ack) begin
      pin_event_flag <= 1'b0;
    end
  end

endmodule // pin_event_detect

/* bench/cause_pin_chk.sv */
/*
  Checker for the reset cause and pin interrupt control block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`include "reset_cause_consts.vh"

module cause_pin_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata,
  input wire pin_irq_req,
  input wire ext_reset_pin_n,
  input wire watchdog_timeout,
  input wire watchdog_en,
  input wire bad_opcode_exec,
  input wire stop_exec,
  input wire stop_allow,
  input wire halt_to_debug_instr,
  input wire halt_to_debug_instr_mode_en,
  input wire bad_address_access,
  input wire low_voltage_trip,
  input wire low_voltage_reset_en,
  input wire debug_force_reset,
  input wire watchdog_clear,
  input wire sys_reset_req
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire any_src = !ext_reset_pin_n | (watchdog_timeout & watchdog_en) | bad_opcode_exec
    | (stop_exec & !stop_allow) | (halt_to_debug_instr & !halt_to_debug_instr_mode_en) | bad_address_access
    | (low_voltage_trip & low_voltage_reset_en) | debug_force_reset;
  wire wr_cause = wr_en && addr == `RESET_CAUSE_ADDR;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_ctrl;
    rd_en && addr == `PIN_CTRL_ADDR;
  endsequence
  sequence s_rd_cause;
    rd_en && addr == `RESET_CAUSE_ADDR;
  endsequence
  sequence s_hold16;
    sys_reset_req [*8] ##1 sys_reset_req [*8];
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ack_reads_zero: assert property (s_rd_ctrl |=> rdata[2] == 1'b0)
    else $error("acknowledge bit read back as one");
  a_irq_follows_flag: assert property (s_rd_ctrl |=> (rdata[3] & rdata[1]) == $past(pin_irq_req))
    else $error("interrupt request differs from flag and enable");
  a_cause_spare_zero: assert property (s_rd_cause |=> (rdata & 8'h05) == 8'h00)
    else $error("spare cause bits read as one");
  a_wdog_clear_pulse: assert property (wr_cause |=> watchdog_clear)
    else $error("watchdog clear missing after cause write");
  a_wdog_clear_quiet: assert property (!wr_cause |=> !watchdog_clear)
    else $error("watchdog clear without cause write");
  a_reset_on_source: assert property (!sys_reset_req && any_src |=> sys_reset_req)
    else $error("active source did not reset");
  a_no_source_quiet: assert property (!sys_reset_req && !any_src |=> !sys_reset_req)
    else $error("reset without active source");
  a_reset_hold_span: assert property ($rose(sys_reset_req) |-> s_hold16)
    else $error("reset request shorter than hold time");
  a_pin_keeps_reset: assert property (sys_reset_req && !ext_reset_pin_n |=> sys_reset_req)
    else $error("reset released while reset pin low");
endmodule // cause_pin_chk

/* bench/test_reset_cause_and_pin_irq_ctrl.sv */
/*
  Self-checking bench for the reset cause and pin interrupt control block.
  Assumes the constants header and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "reset_cause_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end

module test_reset_cause_and_pin_irq_ctrl;
  reg sys_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, irq_pin_in = 0, ext_reset_pin_n = 1;
  reg watchdog_timeout = 0, watchdog_en = 0, bad_opcode_exec = 0, stop_exec = 0;
  reg stop_allow = 0, halt_to_debug_instr = 0, halt_to_debug_instr_mode_en = 0, bad_address_access = 0;
  reg low_voltage_trip = 0, low_voltage_reset_en = 0, debug_force_reset = 0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00, cv, exp_cause;
  wire [7:0] rdata;
  wire pin_irq_req, pin_pull_dis, watchdog_clear, sys_reset_req;
  int fails = 0, compares = 0, i, k;
  logic pol, md, ie, pd;
  logic [11:0] corner [13] = '{12'h001, 12'h003, 12'h004, 12'h008, 12'h018, 12'h020, 12'h060,
    12'h080, 12'h100, 12'h200, 12'h600, 12'h700, 12'h800};

  reset_cause_and_pin_irq_ctrl reset_cause_and_pin_irq_ctrl_i (.*);

  initial forever #(`CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  // ----------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------
  function logic act(input [11:0] s);
    return s[8] | (s[0] & s[1]) | s[2] | (s[3] & !s[4]) | (s[5] & !s[6]) | s[7] | (s[9] & s[10])
      | s[11];
  endfunction
  function logic [7:0] cause_of(input [11:0] s);
    if (s[9] & s[10]) return 8'h02;
    if (s[11]) return 8'h00;
    return {1'b0, s[8], s[0] & s[1], s[2] | (s[3] & !s[4]) | (s[5] & !s[6]), s[7], 3'b000};
  endfunction
  task wr(input [3:0] a, input [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task chk_rd(input [3:0] a, input [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task pin_to(input v);
    @(posedge sys_clk);
    irq_pin_in <= v;
  endtask
  task wait_run;
    for (k = 0; k < 60 && sys_reset_req !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(sys_reset_req, 1'b0)
  endtask
  task fire(input [11:0] s);
    @(posedge sys_clk);
    {debug_force_reset, low_voltage_reset_en, low_voltage_trip} <= s[11:9];
    ext_reset_pin_n <= !s[8];
    {bad_address_access, halt_to_debug_instr_mode_en, halt_to_debug_instr, stop_allow, stop_exec,
      bad_opcode_exec, watchdog_en, watchdog_timeout} <= s[7:0];
    @(posedge sys_clk);
    {debug_force_reset, low_voltage_trip, bad_address_access, halt_to_debug_instr, stop_exec,
      bad_opcode_exec, watchdog_timeout} <= 7'h00;
    #1 `CHK(sys_reset_req, act(s))
    repeat (20) @(posedge sys_clk);
    ext_reset_pin_n <= 1'b1;
    if (act(s)) exp_cause = cause_of(s);
    wait_run;
    chk_rd(`RESET_CAUSE_ADDR, exp_cause);
    wr(`RESET_CAUSE_ADDR, 8'($urandom));
    #1 `CHK(watchdog_clear, 1'b1)
    chk_rd(`RESET_CAUSE_ADDR, exp_cause);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(45834));
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    exp_cause = `CAUSE_POWER_ON_VAL;
    chk_rd(`RESET_CAUSE_ADDR, exp_cause);
    wait_run;
    chk_rd(4'h5, 8'h00);
    $display("test power_on done");
    for (i = 0; i < 4; i++) begin
      pol = i[0];
      md = i[1];
      ie = 1'($urandom);
      pd = 1'($urandom);
      cv = {1'b0, pd, pol, 1'b1, 2'b00, ie, md};
      wr(`PIN_CTRL_ADDR, cv & 8'hef);
      pin_to(!pol);
      pin_to(pol);
      pin_to(!pol);
      chk_rd(`PIN_CTRL_ADDR, cv & 8'hef);
      `CHK(pin_pull_dis, pd)
      wr(`PIN_CTRL_ADDR, cv);
      pin_to(pol);
      pin_to(!pol);
      chk_rd(`PIN_CTRL_ADDR, cv | 8'h08);
      `CHK(pin_irq_req, ie)
      wr(`PIN_CTRL_ADDR, cv | 8'h04);
      chk_rd(`PIN_CTRL_ADDR, cv);
      pin_to(pol);
      wr(`PIN_CTRL_ADDR, cv | 8'h04);
      chk_rd(`PIN_CTRL_ADDR, md ? cv | 8'h08 : cv);
      pin_to(!pol);
      wr(`PIN_CTRL_ADDR, cv | 8'h04);
      chk_rd(`PIN_CTRL_ADDR, cv);
      $display("test pin_event mode %0d polarity %0d done", md, pol);
    end
    foreach (corner[j]) fire(corner[j]);
    for (i = 0; i < 12; i++) fire(12'($urandom & $urandom & $urandom));
    $display("test reset_causes done");
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    tally_and_finish;
  end
endmodule // test_reset_cause_and_pin_irq_ctrl

bind reset_cause_and_pin_irq_ctrl cause_pin_chk cause_pin_chk_i (.*);
